// ==== cmc_top.sv ====
// Codec mode control: control words 0..3, pin-strapped variant, effective settings.
// Assumes a host on the same clock; audio clocks and pins arrive asynchronously.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "cmc_defs.svh"

// Notes on behaviour
// - ADC sleep bit stops the ADC and holds its serial output at zero.
// - High-pass skip bit 0 applies the ADC high-pass filter, 1 bypasses it.
// - DAC sleep bit stops the DAC and grounds the analog outputs; ADC unaffected.
// - Gain share makes the left gain code drive both channels.
// - Zero-run detect opens the amplifier after 65536 zero bit clock cycles.
// - Output force holds DAC outputs at midscale unless DAC sleep grounds them, registers kept.
// - Emphasis field: 00 44.1k, 01 off, 10 48k, 11 32k.
// - Soft silence fades both channel gains together in the digital path.
// - Bits 10..9 select the target word: 10 is word 2, 11 word 3.
// - Echo path sends ADC data into the DAC as I2S; ADC output stays live.
// - Word layout field chooses one of four serial formats.
// - Frame polarity picks which frame clock level means left, formats 0..2.
// - Pin variant sleep pins: both low reset, else each powers down its side.
// - Pin variant emphasis pins decode like the emphasis field.
// - Pin variant wide-word pin picks 16- or 20-bit right justified.
// - Gain code 00 mutes, FF is full scale, others scale by code/256.
module cmc_top
  import cmc_pkg::*;
#(
  parameter int unsigned ZERO_RUN_LEN = `CMC_ZERO_RUN_LEN
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        pin_control,
  input  wire logic        adc_sleep_n_pin,
  input  wire logic        dac_sleep_n_pin,
  input  wire logic        emphasis_pin_low,
  input  wire logic        emphasis_pin_high,
  input  wire logic        wide_word_select,
  input  wire logic        bit_clock_in,
  input  wire logic        frame_clock_in,
  input  wire logic        dac_data_in,
  input  wire logic        adc_data_raw,
  output logic             adc_data_out,
  output logic             dac_data_sel,
  output logic             codec_reset,
  output logic             adc_run,
  output logic             dac_run,
  output logic             analog_out_ground,
  output logic             midscale_level,
  output logic             amp_disconnect,
  output cmc_conv_t        conv_eff,
  output cmc_iface_t       dac_iface,
  output cmc_iface_t       adc_iface,
  output logic             frame_is_left,
  output cmc_gain_t        gain_applied,
  output logic             left_mute,
  output logic             right_mute
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Pin synchronisers
  logic [`CMC_PIN_W-1:0] pin_raw;
  logic [`CMC_PIN_W-1:0] pin_s1_q;
  logic [`CMC_PIN_W-1:0] pin_s2_q;
  logic                  bck_d1_q;
  logic                  lrc_d1_q;
  logic                  bck_rise;
  logic                  lrc_rise;

  assign pin_raw = {adc_data_raw, dac_data_in, frame_clock_in, bit_clock_in,
                    wide_word_select, emphasis_pin_high, emphasis_pin_low, pin_control};

  // No reset: the strap is settled by the time reset ends
  always_ff @(posedge ref_clk) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bck_d1_q <= 1'b0;
      lrc_d1_q <= 1'b0;
    end else begin
      bck_d1_q <= pin_s2_q[4];
      lrc_d1_q <= pin_s2_q[5];
    end
  end

  logic [1:0] slp_s1_q;
  logic [1:0] slp_s2_q;

  // Sleep pins idle high so the pin variant starts running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slp_s1_q <= 2'h3;
      slp_s2_q <= 2'h3;
    end else begin
      slp_s1_q <= {dac_sleep_n_pin, adc_sleep_n_pin};
      slp_s2_q <= slp_s1_q;
    end
  end

  assign bck_rise = pin_s2_q[4] & ~bck_d1_q;
  assign lrc_rise = pin_s2_q[5] & ~lrc_d1_q;

  // Strap caught once after release; changing it later needs a reset
  logic strap_done_q;
  logic pin_mode_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      pin_mode_q   <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      pin_mode_q   <= pin_s2_q[0];
    end
  end

  // ==========================================================
  // Control words
  logic [1:0] wsel;
  cmc_conv_t  conv_q;
  cmc_iface_t iface_q;
  cmc_gain_t  pend_q;
  cmc_gain_t  att_q;

  assign wsel = reg_wdata[`CMC_SEL_MSB:`CMC_SEL_LSB];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= cmc_conv_t'(`CMC_CONV_RST);
    end else if (reg_wr && wsel == `CMC_SEL_CONV) begin
      conv_q <= cmc_conv_t'(reg_wdata[`CMC_CONV_MSB:0]);
    end
  end

  // Reserved bits are not stored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iface_q.echo_path      <= 1'b0;
      iface_q.word_layout    <= cmc_layout_t'(`CMC_LAYOUT_RST);
      iface_q.frame_polarity <= 1'b0;
    end else if (reg_wr && wsel == `CMC_SEL_IFACE) begin
      iface_q.echo_path      <= reg_wdata[`CMC_ECHO_BIT];
      iface_q.word_layout    <= cmc_layout_t'(reg_wdata[`CMC_LAYOUT_MSB:`CMC_LAYOUT_LSB]);
      iface_q.frame_polarity <= reg_wdata[`CMC_POL_BIT];
    end
  end

  // Gain codes wait until a load bit is set, then both channels move together
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q.left  <= `CMC_GAIN_RST;
      pend_q.right <= `CMC_GAIN_RST;
      att_q.left   <= `CMC_GAIN_RST;
      att_q.right  <= `CMC_GAIN_RST;
    end else if (reg_wr && wsel == `CMC_SEL_LEFT) begin
      pend_q.left <= reg_wdata[`CMC_GAIN_MSB:0];
      if (reg_wdata[`CMC_LOAD_BIT]) begin
        att_q.left  <= reg_wdata[`CMC_GAIN_MSB:0];
        att_q.right <= pend_q.right;
      end
    end else if (reg_wr && wsel == `CMC_SEL_RIGHT) begin
      pend_q.right <= reg_wdata[`CMC_GAIN_MSB:0];
      if (reg_wdata[`CMC_LOAD_BIT]) begin
        att_q.left  <= pend_q.left;
        att_q.right <= reg_wdata[`CMC_GAIN_MSB:0];
      end
    end
  end

  // ==========================================================
  // Effective settings, software or pins
  cmc_conv_t  conv_sel;
  cmc_iface_t iface_sel;
  logic       pin_reset;

  always_comb begin
    conv_sel  = conv_q;
    iface_sel = iface_q;
    pin_reset = 1'b0;
    if (pin_mode_q) begin
      conv_sel                 = cmc_conv_t'(`CMC_CONV_RST);
      conv_sel.adc_sleep       = ~slp_s2_q[0];
      conv_sel.dac_sleep       = ~slp_s2_q[1];
      pin_reset                = ~slp_s2_q[0] & ~slp_s2_q[1];
      conv_sel.emphasis_select = cmc_emph_t'({pin_s2_q[2], pin_s2_q[1]});
      iface_sel.echo_path      = 1'b0;
      iface_sel.frame_polarity = 1'b0;
      iface_sel.word_layout    = pin_s2_q[3] ? CMC_FMT_20RJ : CMC_FMT_16RJ;
    end
  end

  // Echo forces I2S on the DAC side; polarity ignored in I2S
  cmc_iface_t dac_if_n;
  cmc_iface_t adc_if_n;

  always_comb begin
    adc_if_n = iface_sel;
    dac_if_n = iface_sel;
    if (iface_sel.echo_path) begin
      dac_if_n.word_layout = CMC_FMT_I2S;
    end
    if (adc_if_n.word_layout == CMC_FMT_I2S) begin
      adc_if_n.frame_polarity = 1'b0;
    end
    if (dac_if_n.word_layout == CMC_FMT_I2S) begin
      dac_if_n.frame_polarity = 1'b0;
    end
  end

  // ==========================================================
  // Gains, shared mode and fade
  cmc_gain_t gain_tgt;
  cmc_gain_t gain_cur;
  logic      amp_open;

  always_comb begin
    gain_tgt = att_q;
    if (conv_sel.gain_share) begin
      gain_tgt.right = att_q.left;
    end
  end

  cmc_gain_ramp u_ramp (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .frame_tick (lrc_rise),
    .silence    (conv_sel.soft_silence),
    .target     (gain_tgt),
    .current    (gain_cur)
  );

  cmc_zero_run #(
    .LEN (ZERO_RUN_LEN)
  ) u_zero (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .enable   (conv_sel.zero_run_detect & ~conv_sel.dac_sleep),
    .bck_rise (bck_rise),
    .data_bit (dac_data_sel),
    .amp_open (amp_open)
  );

  // ==========================================================
  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_eff          <= cmc_conv_t'(`CMC_CONV_RST);
      dac_iface         <= '0;
      adc_iface         <= '0;
      codec_reset       <= 1'b0;
      adc_run           <= 1'b1;
      dac_run           <= 1'b1;
      analog_out_ground <= 1'b0;
      midscale_level    <= 1'b0;
      amp_disconnect    <= 1'b0;
      adc_data_out      <= 1'b0;
      dac_data_sel      <= 1'b0;
      frame_is_left     <= 1'b0;
      gain_applied      <= '1;
      left_mute         <= 1'b0;
      right_mute        <= 1'b0;
    end else begin
      conv_eff          <= conv_sel;
      dac_iface         <= dac_if_n;
      adc_iface         <= adc_if_n;
      codec_reset       <= pin_reset;
      adc_run           <= ~conv_sel.adc_sleep;
      dac_run           <= ~conv_sel.dac_sleep;
      analog_out_ground <= conv_sel.dac_sleep;
      midscale_level    <= conv_sel.out_force & ~conv_sel.dac_sleep;
      amp_disconnect    <= amp_open;
      adc_data_out      <= pin_s2_q[7] & ~conv_sel.adc_sleep;
      // Loopback feeds the raw ADC stream; not gated by the ADC sleep bit
      dac_data_sel      <= iface_sel.echo_path ? pin_s2_q[7] : pin_s2_q[6];
      // I2S marks left with a low frame clock
      frame_is_left     <= (dac_if_n.word_layout == CMC_FMT_I2S) ? ~pin_s2_q[5]
                           : (pin_s2_q[5] ^ dac_if_n.frame_polarity);
      gain_applied      <= gain_cur;
      left_mute         <= (gain_cur.left == `CMC_GAIN_MUTE);
      right_mute        <= (gain_cur.right == `CMC_GAIN_MUTE);
    end
  end

  // ==========================================================
  // Read port, data valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `CMC_READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `CMC_ADDR_LEFT:  reg_rdata <= {5'h00, `CMC_SEL_LEFT, 1'b0, att_q.left};
        `CMC_ADDR_RIGHT: reg_rdata <= {5'h00, `CMC_SEL_RIGHT, 1'b0, att_q.right};
        `CMC_ADDR_CONV:  reg_rdata <= {5'h00, `CMC_SEL_CONV, conv_q};
        `CMC_ADDR_IFACE: reg_rdata <= {5'h00, `CMC_SEL_IFACE, 3'h0, iface_q.echo_path,
                                       1'b0, iface_q.word_layout, iface_q.frame_polarity,
                                       1'b0};
        `CMC_ADDR_STAT:  reg_rdata <= {8'h00, pin_mode_q, pin_reset, amp_open,
                                       ~conv_sel.adc_sleep, ~conv_sel.dac_sleep,
                                       gain_cur.left == `CMC_GAIN_MUTE,
                                       gain_cur.right == `CMC_GAIN_MUTE,
                                       gain_cur == gain_tgt};
        default:         reg_rdata <= `CMC_READ_ZERO;
      endcase
    end else begin
      reg_rdata <= `CMC_READ_ZERO;
    end
  end

endmodule : cmc_top

// ==== cmc_defs.svh ====
// Named offsets, field positions, reset values and counts for the codec mode control.
// Assumes inclusion by bare name from the design modules; definitions only.
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

// ==========================================================
// Control word layout
`define CMC_SEL_MSB        10
`define CMC_SEL_LSB        9
`define CMC_LOAD_BIT       8
`define CMC_GAIN_MSB       7
`define CMC_CONV_MSB       8
`define CMC_ECHO_BIT       5
`define CMC_LAYOUT_MSB     3
`define CMC_LAYOUT_LSB     2
`define CMC_POL_BIT        1

// ==========================================================
// Word select codes
`define CMC_SEL_LEFT       2'h0
`define CMC_SEL_RIGHT      2'h1
`define CMC_SEL_CONV       2'h2
`define CMC_SEL_IFACE      2'h3

// ==========================================================
// Read addresses
`define CMC_ADDR_LEFT      3'h0
`define CMC_ADDR_RIGHT     3'h1
`define CMC_ADDR_CONV      3'h2
`define CMC_ADDR_IFACE     3'h3
`define CMC_ADDR_STAT      3'h4

// ==========================================================
// Reset values and mute code
`define CMC_GAIN_RST       8'hff
`define CMC_GAIN_MUTE      8'h00
`define CMC_CONV_RST       9'h002
`define CMC_LAYOUT_RST     2'h0
`define CMC_READ_ZERO      16'h0000

// ==========================================================
// Counts
`define CMC_ZERO_RUN_LEN   65536
`define CMC_ZR_CNT_W       17
`define CMC_PIN_W          8

`endif

// ==== cmc_pkg.sv ====
// Types shared by the codec mode control modules.
// Assumes the constants header is included where numbers are needed.
package cmc_pkg;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    CMC_EMP_441 = 2'b00,
    CMC_EMP_OFF = 2'b01,
    CMC_EMP_48  = 2'b10,
    CMC_EMP_32  = 2'b11
  } cmc_emph_t;

  typedef enum logic [1:0] {
    CMC_FMT_16RJ = 2'b00,
    CMC_FMT_20RJ = 2'b01,
    CMC_FMT_20LJ = 2'b10,
    CMC_FMT_I2S  = 2'b11
  } cmc_layout_t;

  typedef enum logic [1:0] {
    CMC_ZR_IDLE  = 2'b00,
    CMC_ZR_COUNT = 2'b01,
    CMC_ZR_OPEN  = 2'b10
  } cmc_zr_state_t;

  // ==========================================================
  // Carriers: field order matches word 2 bits 8..0
  typedef struct packed {
    logic      adc_sleep;
    logic      hpf_skip;
    logic      dac_sleep;
    logic      gain_share;
    logic      zero_run_detect;
    logic      out_force;
    cmc_emph_t emphasis_select;
    logic      soft_silence;
  } cmc_conv_t;

  typedef struct packed {
    logic        echo_path;
    cmc_layout_t word_layout;
    logic        frame_polarity;
  } cmc_iface_t;

  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
  } cmc_gain_t;

endpackage : cmc_pkg

// ==== cmc_zero_run.sv ====
// Zero-run detector: opens the output amplifier path after a long zero input.
// Assumes bck_rise is a one-cycle pulse on the system clock per bit clock rise.
`timescale 1ns/10ps
`include "cmc_defs.svh"
module cmc_zero_run
  import cmc_pkg::*;
#(
  parameter int unsigned LEN = `CMC_ZERO_RUN_LEN
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic bck_rise,
  input  wire logic data_bit,
  output logic      amp_open
);

  cmc_zr_state_t           state_q;
  logic [`CMC_ZR_CNT_W-1:0] count_q;

  // ==========================================================
  // Run counter, bit clock cycles with data held low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CMC_ZR_IDLE;
      count_q <= '0;
    end else begin
      case (state_q)
        CMC_ZR_IDLE: begin
          count_q <= '0;
          if (enable) begin
            state_q <= CMC_ZR_COUNT;
          end
        end
        CMC_ZR_COUNT: begin
          if (!enable) begin
            state_q <= CMC_ZR_IDLE;
          end else if (bck_rise) begin
            if (data_bit) begin
              count_q <= '0;
            end else if (count_q == `CMC_ZR_CNT_W'(LEN - 1)) begin
              state_q <= CMC_ZR_OPEN;
            end else begin
              count_q <= count_q + `CMC_ZR_CNT_W'(1);
            end
          end
        end
        CMC_ZR_OPEN: begin
          // Any nonzero bit reconnects at once
          if (!enable || (bck_rise && data_bit)) begin
            state_q <= enable ? CMC_ZR_COUNT : CMC_ZR_IDLE;
            count_q <= '0;
          end
        end
        default: begin
          state_q <= CMC_ZR_IDLE;
        end
      endcase
    end
  end

  assign amp_open = (state_q == CMC_ZR_OPEN);

endmodule : cmc_zero_run

// ==== cmc_gain_ramp.sv ====
// Gain ramp: walks the applied channel gains toward their targets once per frame.
// Assumes frame_tick is a one-cycle pulse per frame clock rise.
`timescale 1ns/10ps
module cmc_gain_ramp
  import cmc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      frame_tick,
  input  wire logic      silence,
  input  cmc_gain_t      target,
  output cmc_gain_t      current
);
`include "cmc_defs.svh"

  cmc_gain_t cur_q;

  // One code per frame, so mute fades instead of clicking
  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      step_to = cur + 8'h01;
    end else if (cur > tgt) begin
      step_to = cur - 8'h01;
    end else begin
      step_to = cur;
    end
  endfunction : step_to

  // ==========================================================
  // Ramp
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q.left  <= `CMC_GAIN_RST;
      cur_q.right <= `CMC_GAIN_RST;
    end else if (frame_tick) begin
      cur_q.left  <= step_to(cur_q.left,  silence ? `CMC_GAIN_MUTE : target.left);
      cur_q.right <= step_to(cur_q.right, silence ? `CMC_GAIN_MUTE : target.right);
    end
  end

  assign current = cur_q;

endmodule : cmc_gain_ramp

// ==== cmc_assertions.sv ====
// Concurrent checks on the codec mode control top ports.
// Assumes the pin strap stays constant between resets.
`timescale 1ns/10ps
module cmc_checker
  import cmc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [2:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        pin_control,
  input wire logic        adc_sleep_n_pin,
  input wire logic        dac_sleep_n_pin,
  input wire logic        emphasis_pin_low,
  input wire logic        emphasis_pin_high,
  input wire logic        adc_data_out,
  input wire logic        adc_run,
  input wire logic        dac_run,
  input wire logic        analog_out_ground,
  input wire logic        midscale_level,
  input cmc_conv_t        conv_eff,
  input cmc_iface_t       dac_iface,
  input cmc_iface_t       adc_iface,
  input cmc_gain_t        gain_applied,
  input wire logic        left_mute,
  input wire logic        right_mute
);
  // ==========
  // Settle counter: strap and pin syncs need time after reset
  logic [3:0] up_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hf) begin
      up_q <= up_q + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ==========
  // Checks
  a_conv_write: assert property (
    reg_wr && reg_wdata[10:9] == 2'h2 && !pin_control |-> ##2 conv_eff == $past(reg_wdata[8:0], 2))
    else $error("word 2 fields not applied");
  a_iface_write: assert property (
    reg_wr && reg_wdata[10:9] == 2'h3 && !pin_control
    |-> ##2 adc_iface.word_layout == $past(reg_wdata[3:2], 2))
    else $error("word 3 layout not applied");
  a_echo_i2s: assert property (
    dac_iface.echo_path |-> dac_iface.word_layout == CMC_FMT_I2S)
    else $error("echo path without I2S");
  a_i2s_no_pol: assert property (
    adc_iface.word_layout == CMC_FMT_I2S |-> !adc_iface.frame_polarity)
    else $error("polarity active in I2S");
  a_adc_sleep: assert property (
    conv_eff.adc_sleep && $past(conv_eff.adc_sleep) |-> !adc_data_out && !adc_run)
    else $error("ADC output live while asleep");
  a_dac_sleep: assert property (
    conv_eff.dac_sleep && $past(conv_eff.dac_sleep)
    |-> analog_out_ground && !dac_run && !midscale_level)
    else $error("DAC not grounded while asleep");
  a_force_mid: assert property (
    $past(conv_eff.out_force && !conv_eff.dac_sleep) && conv_eff.out_force && !conv_eff.dac_sleep
    |-> midscale_level)
    else $error("output force not at midscale");
  a_mute_flags: assert property (
    $past(gain_applied) == gain_applied && $past(gain_applied, 2) == gain_applied
    |-> left_mute == (gain_applied.left == 8'h00) && right_mute == (gain_applied.right == 8'h00))
    else $error("mute flag disagrees with gain");
  a_ramp_step: assert property (
    8'(gain_applied.left - $past(gain_applied.left)) inside {8'h00, 8'h01, 8'hff}
    && 8'(gain_applied.right - $past(gain_applied.right)) inside {8'h00, 8'h01, 8'hff})
    else $error("gain jumped more than one code");
  a_pin_decode: assert property (
    (pin_control && up_q == 4'hf && $stable({adc_sleep_n_pin, dac_sleep_n_pin,
    emphasis_pin_low, emphasis_pin_high})) [*8]
    |-> conv_eff.emphasis_select == {emphasis_pin_high, emphasis_pin_low}
        && adc_run == adc_sleep_n_pin && dac_run == dac_sleep_n_pin)
    else $error("pin strap decode wrong");
  a_read_sel: assert property (
    reg_rd && reg_addr == 3'h3 |=> reg_rdata[15:9] == 7'h03)
    else $error("word 3 readback select wrong");
endmodule : cmc_checker

bind cmc_top cmc_checker cmc_checker_i (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .pin_control, .adc_sleep_n_pin, .dac_sleep_n_pin, .emphasis_pin_low,
  .emphasis_pin_high, .adc_data_out, .adc_run, .dac_run, .analog_out_ground, .midscale_level,
  .conv_eff, .dac_iface, .adc_iface, .gain_applied, .left_mute, .right_mute);

// ==== cmc_audio_src.sv ====
// Audio clock and data source standing in for the far-side serial master.
// Assumes ref_clk; bit clock is ref_clk/4, sixteen bit clocks per frame.
`timescale 1ns/10ps
module cmc_audio_src (
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic data_hi,
  output logic      bit_clock_in,
  output logic      frame_clock_in,
  output logic      dac_data_in
);
  // ==========
  // Clocks stand still outside frames
  logic [5:0] ph_q;
  logic       tg_q;
  initial {bit_clock_in, frame_clock_in, dac_data_in, ph_q, tg_q} = '0;
  always @(posedge ref_clk) begin
    tg_q <= ~tg_q;
    if (!run) begin
      ph_q <= 6'h00;
      bit_clock_in <= 1'b0;
      frame_clock_in <= 1'b0;
      dac_data_in <= tg_q;  // Released line must not look like held data
    end else begin
      ph_q <= ph_q + 6'h01;
      bit_clock_in <= ph_q[1];
      frame_clock_in <= ph_q[5];
      dac_data_in <= data_hi;
    end
  end
endmodule : cmc_audio_src

// ==== tb_top.sv ====
// Self-checking bench for the codec mode control block.
// Assumes the design, checker and audio source model are compiled first.
`timescale 1ns/10ps
module tb_top
  import cmc_pkg::*;
;
  logic        ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic        pin_control = 1'b0, adc_sleep_n_pin = 1'b1, dac_sleep_n_pin = 1'b1;
  logic        emphasis_pin_low = 1'b1, emphasis_pin_high = 1'b0, wide_word_select = 1'b0;
  logic        adc_data_raw = 1'b1, run = 1'b0, data_hi = 1'b0;
  logic        bit_clock_in, frame_clock_in, dac_data_in, adc_data_out, dac_data_sel;
  logic        codec_reset, adc_run, dac_run, analog_out_ground, midscale_level;
  logic        amp_disconnect, frame_is_left, left_mute, right_mute;
  cmc_conv_t   conv_eff;
  cmc_iface_t  dac_iface, adc_iface;
  cmc_gain_t   gain_applied;
  int          fails = 0, compares = 0, cyc = 0;

  typedef struct packed {
    logic [15:0] w;
    logic [8:0]  conv;
    logic [3:0]  fl;  // adc_run, dac_run, ground, midscale
  } cmc_row_t;
  cmc_row_t rows [10] = '{'{16'h0400, 9'h000, 4'hc}, '{16'h0404, 9'h004, 4'hc},
    '{16'h0406, 9'h006, 4'hc}, '{16'h0402, 9'h002, 4'hc}, '{16'h0502, 9'h102, 4'h4},
    '{16'h0482, 9'h082, 4'hc}, '{16'h0442, 9'h042, 4'ha}, '{16'h040a, 9'h00a, 4'hd},
    '{16'h044a, 9'h04a, 4'ha}, '{16'h0422, 9'h022, 4'hc}};

  cmc_top #(.ZERO_RUN_LEN(16)) cmc_top_i (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pin_control, .adc_sleep_n_pin, .dac_sleep_n_pin, .emphasis_pin_low,
    .emphasis_pin_high, .wide_word_select, .bit_clock_in, .frame_clock_in, .dac_data_in,
    .adc_data_raw, .adc_data_out, .dac_data_sel, .codec_reset, .adc_run, .dac_run,
    .analog_out_ground, .midscale_level, .amp_disconnect, .conv_eff, .dac_iface, .adc_iface,
    .frame_is_left, .gain_applied, .left_mute, .right_mute);
  cmc_audio_src cmc_audio_src_i (.ref_clk, .run, .data_hi, .bit_clock_in, .frame_clock_in,
    .dac_data_in);

  always #5 ref_clk = ~ref_clk;

  // ==========
  // Tasks
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [15:0] w);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_wdata <= w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic do_reset(input logic pins);
    nrst <= 1'b0;
    pin_control <= pins;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    settle(20);  // Long enough for the checker's settle counter too
  endtask : do_reset

  task automatic wait_gain(input logic [15:0] exp);
    int n;
    n = 0;
    while (gain_applied !== exp && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    settle(2);
    chk("gain", exp, gain_applied);
  endtask : wait_gain

  // Ceiling well above the longest expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      give_verdict();
    end
  end

  // ==========
  // Sequence
  initial begin
    do_reset(1'b0);
    chk("rst_conv", 16'h0002, conv_eff);
    chk("rst_gain", 16'hffff, gain_applied);
    foreach (rows[i]) begin
      wr(rows[i].w);
      settle(3);
      chk("conv_eff", rows[i].conv, conv_eff);
      chk("flags", rows[i].fl, {adc_run, dac_run, analog_out_ground, midscale_level});
      chk("adc_out", rows[i].fl[3], adc_data_out);
      rd(3'h2);
      chk("readback", {7'h02, rows[i].conv}, d);
    end
    for (int f = 0; f < 8; f++) begin
      wr({5'h00, 2'h3, 5'h00, f[2:1], f[0], 1'b0});
      settle(3);
      chk("layout", f[2:1], adc_iface.word_layout);
      chk("polarity", f[0] && f[2:1] != 2'h3, adc_iface.frame_polarity);
      chk("left", f[0] || f[2:1] == 2'h3, frame_is_left);
    end
    chk("conv_kept", 16'h0022, conv_eff);
    wr(16'h0620);
    settle(6);
    chk("echo_fmt", {1'b1, CMC_FMT_I2S, 1'b0}, dac_iface);
    chk("echo_src", 1'b1, dac_data_sel);
    chk("echo_adc", 1'b1, adc_data_out);
    rd(3'h3);
    chk("rb_word3", 16'h0620, d);
    wr(16'h0600);
    rd(3'h5);
    chk("unmapped", 16'h0000, d);
    run <= 1'b1;
    wr(16'h01f0);
    wait_gain(16'hf0f0);
    wr(16'h0402);
    wr(16'h02e0);
    wr(16'h03e0);
    wait_gain(16'hf0e0);
    wr(16'h0403);
    wait_gain(16'h0000);
    chk("mutes", 2'h3, {left_mute, right_mute});
    wr(16'h0402);
    wait_gain(16'hf0e0);
    settle(150);
    chk("zr_off", 1'b0, amp_disconnect);
    wr(16'h0412);
    settle(44);
    chk("zr_early", 1'b0, amp_disconnect);
    settle(80);
    chk("zr_open", 1'b1, amp_disconnect);
    data_hi <= 1'b1;
    settle(20);
    chk("zr_close", 1'b0, amp_disconnect);
    run <= 1'b0;
    do_reset(1'b1);
    for (int p = 0; p < 16; p++) begin
      @(posedge ref_clk);
      adc_sleep_n_pin <= p[0];
      dac_sleep_n_pin <= p[1];
      emphasis_pin_low <= p[2];
      emphasis_pin_high <= p[3];
      wide_word_select <= p[2];
      settle(12);
      chk("pin_emph", p[3:2], conv_eff.emphasis_select);
      chk("pin_run", {p[1:0] == 2'h0, p[0], p[1]}, {codec_reset, adc_run, dac_run});
      chk("pin_fmt", {p[2], p[2]}, {adc_iface.word_layout[0], dac_iface.word_layout[0]});
    end
    wr(16'h0400);
    settle(4);
    chk("pin_hold", 2'h3, conv_eff.emphasis_select);
    give_verdict();
  end
endmodule : tb_top
